//--- common/dac_bank_consts.vh
// Constants of the eight-channel DAC bank update control.
// Included by the design file; definitions only.
`ifndef DAC_BANK_CONSTS_VH
`define DAC_BANK_CONSTS_VH

// Register offsets
`define OFS_CONFIG_ZERO 8'h10
`define OFS_UPDATE_MODE 8'h15
`define OFS_RANGE_SELECT 8'h16
`define OFS_CLAMP 8'h17
`define OFS_TRIGGER 8'h1c
`define OFS_CODE_FIRST 8'h30
`define OFS_CODE_LAST 8'h37
`define OFS_LIMIT_A 8'h4e
`define OFS_LIMIT_B 8'h4f

// Field positions
`define BIT_LOOP_ENABLE 0
`define BIT_SOFT_UPDATE 0
`define RANGE_PAIR_A_LO 0
`define RANGE_PAIR_B_LO 2
`define RANGE_AUX_LO 4
`define CLAMP_PAIR_A 0
`define CLAMP_PAIR_B 1
`define CLAMP_AUX_LO 2

// Range encodings of a bipolar pair
`define RANGE_0_TO_5 2'h0
`define RANGE_M5_TO_0 2'h1
`define RANGE_M4_TO_1 2'h2

// Reset values
`define RST_CONFIG_ZERO 8'h00
`define RST_UPDATE_MODE 8'h00
`define RST_RANGE_SELECT 8'h00
`define RST_CLAMP 6'h3f
`define RST_CODE 12'h000
`define RST_LIMIT 12'hfff

`endif

//--- rtl/dac_bank_update_control.v
// Digital control of an eight-channel 12-bit DAC bank: ranges, clamp, loop mode,
// double-buffered codes with asynchronous or triggered update.
// Assumes a one-cycle strobe register port and synchronous pin inputs.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dac_bank_consts.vh"

module dac_bank_update_control #(
  parameter CHANNELS = 8,
  parameter CODE_W = 12
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  // Trigger pin, active on its rising edge
  input wire update_strobe_pin,
  // Supply monitor and loop controller
  input wire supply_valid,
  input wire [3:0] loop_code_valid,
  input wire [4*CODE_W-1:0] loop_code,
  // Converter side
  output reg [CHANNELS*CODE_W-1:0] active_code,
  output reg [1:0] pair_a_range,
  output reg [1:0] pair_b_range,
  output reg [3:0] aux_range,
  output reg [CHANNELS-1:0] channel_clamp,
  output reg [3:0] supply_clamp,
  output reg loop_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg [7:0] config_zero;
  reg [7:0] update_mode;
  reg [7:0] range_select;
  reg [5:0] clamp_bits;
  reg [CODE_W-1:0] limit_a;
  reg [CODE_W-1:0] limit_b;
  reg [CODE_W-1:0] buffer_code [0:CHANNELS-1];
  reg [CODE_W-1:0] active_reg [0:CHANNELS-1];
  reg trigger_pin_last;
  reg [15:0] next_rdata;

  wire loop_on;
  wire soft_trigger;
  wire pin_trigger;
  wire trigger;
  wire code_write;
  wire [2:0] code_index;
  integer i;
  integer j;

  // Clamp one loop request to its limit
  function [CODE_W-1:0] limit_code;
    input [CODE_W-1:0] request;
    input [CODE_W-1:0] limit;
    begin
      if (request > limit) begin
        limit_code = limit;
      end else begin
        limit_code = request;
      end
    end
  endfunction

  // True when the address names a channel code register
  function is_code_addr;
    input [7:0] addr;
    begin
      is_code_addr = (addr >= `OFS_CODE_FIRST) && (addr <= `OFS_CODE_LAST);
    end
  endfunction

  assign loop_on = config_zero[`BIT_LOOP_ENABLE];
  assign soft_trigger = reg_write && (reg_addr == `OFS_TRIGGER) &&
                        reg_wdata[`BIT_SOFT_UPDATE];
  // Rising level on the pin counts once
  assign pin_trigger = update_strobe_pin && !trigger_pin_last;
  assign trigger = soft_trigger || pin_trigger;
  assign code_write = reg_write && is_code_addr(reg_addr);
  assign code_index = reg_addr[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_zero <= `RST_CONFIG_ZERO;
      update_mode <= `RST_UPDATE_MODE;
      range_select <= `RST_RANGE_SELECT;
      clamp_bits <= `RST_CLAMP;
      limit_a <= `RST_LIMIT;
      limit_b <= `RST_LIMIT;
      trigger_pin_last <= 1'b0;
    end else begin
      trigger_pin_last <= update_strobe_pin;
      if (reg_write) begin
        case (reg_addr)
          `OFS_CONFIG_ZERO: begin
            config_zero <= reg_wdata[7:0];
          end
          `OFS_UPDATE_MODE: begin
            update_mode <= reg_wdata[7:0];
          end
          `OFS_RANGE_SELECT: begin
            range_select <= reg_wdata[7:0];
          end
          `OFS_CLAMP: begin
            clamp_bits <= reg_wdata[5:0];
          end
          `OFS_LIMIT_A: begin
            limit_a <= reg_wdata[CODE_W-1:0];
          end
          `OFS_LIMIT_B: begin
            limit_b <= reg_wdata[CODE_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer and active code registers; clamp never touches them

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        buffer_code[i] <= `RST_CODE;
        active_reg[i] <= `RST_CODE;
      end
    end else begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (i < 4 && loop_on) begin
          // Loop drives bipolar channels, host codes ignored
          if (loop_code_valid[i]) begin
            active_reg[i] <= limit_code(loop_code[i*CODE_W +: CODE_W],
                                        (i < 2) ? limit_a : limit_b);
          end
        end else if (code_write && code_index == i) begin
          buffer_code[i] <= reg_wdata[CODE_W-1:0];
          if (!update_mode[i]) begin
            active_reg[i] <= reg_wdata[CODE_W-1:0];
          end else if (trigger) begin
            active_reg[i] <= buffer_code[i];
          end
        end else if (trigger && update_mode[i]) begin
          active_reg[i] <= buffer_code[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter-side outputs

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_code <= {CHANNELS*CODE_W{1'b0}};
      pair_a_range <= `RANGE_0_TO_5;
      pair_b_range <= `RANGE_0_TO_5;
      aux_range <= 4'h0;
      channel_clamp <= {CHANNELS{1'b1}};
      supply_clamp <= 4'h0;
      loop_mode <= 1'b0;
    end else begin
      for (j = 0; j < CHANNELS; j = j + 1) begin
        active_code[j*CODE_W +: CODE_W] <= active_reg[j];
      end
      pair_a_range <= range_select[`RANGE_PAIR_A_LO +: 2];
      pair_b_range <= range_select[`RANGE_PAIR_B_LO +: 2];
      aux_range <= range_select[`RANGE_AUX_LO +: 4];
      channel_clamp <= {clamp_bits[`CLAMP_AUX_LO +: 4],
                        {2{clamp_bits[`CLAMP_PAIR_B]}},
                        {2{clamp_bits[`CLAMP_PAIR_A]}}};
      supply_clamp <= {4{!supply_valid}};
      loop_mode <= loop_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe

  always @* begin
    next_rdata = 16'h0000;
    if (is_code_addr(reg_addr)) begin
      next_rdata[CODE_W-1:0] = active_reg[code_index];
    end else begin
      case (reg_addr)
        `OFS_CONFIG_ZERO: next_rdata[7:0] = config_zero;
        `OFS_UPDATE_MODE: next_rdata[7:0] = update_mode;
        `OFS_RANGE_SELECT: next_rdata[7:0] = range_select;
        `OFS_CLAMP: next_rdata[5:0] = clamp_bits;
        `OFS_LIMIT_A: next_rdata[CODE_W-1:0] = limit_a;
        `OFS_LIMIT_B: next_rdata[CODE_W-1:0] = limit_b;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

//--- test/sense_loop.sv
// Loop controller stand-in: offers one sense result to channel 0.
// Assumes the bench drives go and req just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sense_loop (
  // Bench side
  input wire logic go,
  input wire logic [11:0] req,
  // Converter side
  output logic [3:0] loop_code_valid,
  output logic [47:0] loop_code
);
  assign loop_code_valid = {3'h0, go};
  // Stale data is inverted outside a valid cycle
  assign loop_code = go ? {4{req}} : ~{4{req}};
endmodule
`default_nettype wire

//--- test/dac_bank_monitor.sv
// Port checker for the DAC bank update control.
// Assumes the single clock ref_clk and active-low reset rst_b.
`timescale 1ns/1ps
`default_nettype none
module dac_bank_monitor (
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic update_strobe_pin,
  input wire logic supply_valid,
  input wire logic [3:0] loop_code_valid,
  input wire logic [47:0] loop_code,
  input wire logic [95:0] active_code,
  input wire logic [7:0] channel_clamp,
  input wire logic [3:0] supply_clamp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_rst; $rose(rst_b) |-> channel_clamp == 8'hff && active_code == 96'h0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_rd;
    reg_read && reg_addr[7:3] == 5'h06
      |=> reg_rdata == {4'h0, active_code[$past(reg_addr[2:0]) * 12 +: 12]};
  endproperty
  a_rd: assert property (p_rd) else $error("read not active code");
  property p_wo; reg_read && reg_addr == 8'h1c |=> reg_rdata == 16'h0000; endproperty
  a_wo: assert property (p_wo) else $error("trigger register readable");
  property p_clamp;
    reg_write && reg_addr == 8'h17 && reg_wdata[5:0] == 6'h00 |-> ##[1:2] channel_clamp == 8'h00;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp not released");
  property p_sup; supply_clamp == {4{!$past(supply_valid)}}; endproperty
  a_sup: assert property (p_sup) else $error("supply clamp wrong");
  property p_cause;
    active_code != $past(active_code) |-> $past(reg_write, 2) || $past(loop_code_valid[0], 2)
      || $past(update_strobe_pin, 2) || $past(update_strobe_pin, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("code changed without cause");
  property p_loop;
    $past(supply_valid) && loop_code_valid[0] |-> ##2 active_code[11:0] <= $past(loop_code[11:0], 2);
  endproperty
  a_loop: assert property (p_loop) else $error("loop code above request");
  c_rd: cover property (reg_read && reg_addr == 8'h32);
  c_pin: cover property ($rose(update_strobe_pin));
  c_loop: cover property (loop_code_valid[0]);
endmodule
bind dac_bank_update_control dac_bank_monitor dac_bank_monitor_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .update_strobe_pin(update_strobe_pin), .supply_valid(supply_valid),
  .loop_code_valid(loop_code_valid), .loop_code(loop_code), .active_code(active_code),
  .channel_clamp(channel_clamp), .supply_clamp(supply_clamp)
);
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the DAC bank update control.
// Assumes the register port and loop stand-in as wired below.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'h0, rst_b = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
  logic update_strobe_pin = 1'h0, supply_valid = 1'h1, go = 1'h0, loop_mode;
  logic [7:0] reg_addr = 8'h00, channel_clamp;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [11:0] req = 12'h000;
  logic [1:0] pair_a_range, pair_b_range;
  logic [3:0] loop_code_valid, supply_clamp, aux_range;
  logic [47:0] loop_code;
  logic [95:0] active_code;
  int bad_count = 0, total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  dac_bank_update_control dac_bank_update_control_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .update_strobe_pin(update_strobe_pin), .supply_valid(supply_valid),
    .loop_code_valid(loop_code_valid), .loop_code(loop_code), .active_code(active_code),
    .pair_a_range(pair_a_range), .pair_b_range(pair_b_range), .aux_range(aux_range),
    .channel_clamp(channel_clamp), .supply_clamp(supply_clamp), .loop_mode(loop_mode)
  );
  sense_loop sense_loop_i (
    .go(go), .req(req), .loop_code_valid(loop_code_valid), .loop_code(loop_code)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge ref_clk);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge ref_clk);
    reg_read <= 1'h0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask
  task automatic send(input logic [11:0] v);
    @(posedge ref_clk);
    go <= 1'h1;
    req <= v;
    @(posedge ref_clk);
    go <= 1'h0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(negedge ref_clk);
    chk({8'h00, channel_clamp}, 16'h00ff);
    rd(8'h37, 16'h0000);
    wr(8'h17, 16'h0000);
    wr(8'h16, 16'h00a6);
    repeat (2) @(negedge ref_clk);
    chk({8'h00, channel_clamp}, 16'h0000);
    chk({8'h00, aux_range, pair_b_range, pair_a_range}, 16'h00a6);
    wr(8'h31, 16'h0abc);
    rd(8'h31, 16'h0abc);
    wr(8'h15, 16'h000c);
    wr(8'h32, 16'h0555);
    wr(8'h33, 16'h0123);
    rd(8'h32, 16'h0000);
    wr(8'h1c, 16'h0001);
    rd(8'h32, 16'h0555);
    rd(8'h33, 16'h0123);
    rd(8'h1c, 16'h0000);
    wr(8'h32, 16'h0777);
    @(posedge ref_clk) update_strobe_pin <= 1'h1;
    @(posedge ref_clk) update_strobe_pin <= 1'h0;
    rd(8'h32, 16'h0777);
    wr(8'h17, 16'h0003);
    wr(8'h17, 16'h0000);
    chk({4'h0, active_code[23:12]}, 16'h0abc);
    @(posedge ref_clk) supply_valid <= 1'h0;
    repeat (2) @(negedge ref_clk);
    chk({12'h000, supply_clamp}, 16'h000f);
    @(posedge ref_clk) supply_valid <= 1'h1;
    wr(8'h4e, 16'h0100);
    wr(8'h10, 16'h0001);
    send(12'h200);
    chk({15'h0000, loop_mode}, 16'h0001);
    rd(8'h30, 16'h0100);
    send(12'h050);
    wr(8'h30, 16'h0003);
    rd(8'h30, 16'h0050);
    wr(8'h10, 16'h0000);
    wr(8'h30, 16'h0003);
    rd(8'h30, 16'h0003);
    close_out;
  end
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
